// >>> verilog/dsp_ctrl_pkg.sv
// Purpose: Constants for the control, move and port input executor.
// Assumes: Registers are 32-bit words on classic Wishbone.
// Notes:   Data addresses are resolved by software before issue.
package dsp_ctrl_pkg;

  localparam logic [7:0]  OFS_COMMAND   = 8'h00;
  localparam logic [7:0]  OFS_ADDRESS   = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_RAM_ADDR  = 8'h0C;
  localparam logic [7:0]  OFS_RAM_DATA  = 8'h10;
  localparam logic [7:0]  OFS_LAST_READ = 8'h14;

  localparam int          STAT_CFG_LOW  = 0;
  localparam int          STAT_CFG_HIGH = 1;
  localparam int          STAT_MASK     = 2;
  localparam int          STAT_FORMAT   = 3;
  localparam int          STAT_BUSY     = 4;

  localparam logic [1:0]  CNF_RESET     = 2'h0;
  localparam logic        MASK_RESET    = 1'h1;
  localparam logic        FORMAT_RESET  = 1'h0;

  localparam logic [13:0] OP_CONF       = 14'h338F;
  localparam logic [15:0] OP_MASK_SET   = 16'hCE01;
  localparam logic [15:0] OP_MASK_CLR   = 16'hCE00;
  localparam logic [14:0] OP_FORMAT     = 15'h6707;
  localparam logic [7:0]  OP_MOVE_HI    = 8'h56;
  localparam logic [7:0]  OP_LTD_HI     = 8'h4A;
  localparam logic [7:0]  OP_MAC_HI     = 8'h5D;
  localparam logic [3:0]  OP_IN_HI      = 4'h8;

  localparam logic [15:0] B0_BASE       = 16'h0200;
  localparam logic [15:0] B1_BASE       = 16'h0300;
  localparam logic [15:0] B1_END        = 16'h0400;
  localparam logic [15:0] B2_BASE       = 16'h0060;
  localparam int          B2_WORDS      = 32;
  localparam int          B01_WORDS     = 512;

endpackage : dsp_ctrl_pkg

// >>> verilog/dsp_ctrl_move_io.sv
//
// Purpose: Executes configuration, mask, format, delay move and port input.
// Assumes: Pins are synchronised here; one instruction runs at a time.
// Notes:   Writing the command register starts execution.
`timescale 1ns/10ps
module dsp_ctrl_move_io (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  output logic      [15:0] ext_addr_o,
  input  wire logic [15:0] ext_data_i,
  output logic      [15:0] ext_data_o,
  output logic             ext_data_oe_o,
  output logic             bus_strobe_n_o,
  output logic             read_write_o,
  output logic             io_select_line_n_o,
  output logic             data_select_n_o,
  input  wire logic        ready_i,
  output logic             ram_config_low_bit_o,
  output logic             ram_config_high_bit_o,
  output logic             interrupt_mask_bit_o,
  output logic             serial_format_bit_o,
  output logic             busy_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Types, functions and storage.

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_EXEC  = 4'h2,
    S_READ  = 4'h4,
    S_WRITE = 4'h8
  } state_t;

  localparam int RAM_WORDS = dsp_ctrl_pkg::B01_WORDS + dsp_ctrl_pkg::B2_WORDS;

  function automatic logic on_chip_data(input logic [15:0] a, input logic [1:0] cnf);
    on_chip_data = (a >= dsp_ctrl_pkg::B0_BASE && a < dsp_ctrl_pkg::B1_BASE && cnf == 2'h0)
      || (a >= dsp_ctrl_pkg::B1_BASE && a < dsp_ctrl_pkg::B1_END && !cnf[1])
      || (a >= dsp_ctrl_pkg::B2_BASE
          && a < dsp_ctrl_pkg::B2_BASE + 16'(dsp_ctrl_pkg::B2_WORDS));
  endfunction : on_chip_data

  function automatic logic [9:0] ram_index(input logic [15:0] a);
    if (a >= dsp_ctrl_pkg::B0_BASE) begin
      ram_index = 10'(a - dsp_ctrl_pkg::B0_BASE);
    end else begin
      ram_index = 10'(a - dsp_ctrl_pkg::B2_BASE) + 10'(dsp_ctrl_pkg::B01_WORDS);
    end
  endfunction : ram_index

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  logic [15:0] ram [0:RAM_WORDS-1];
  state_t      state;
  logic [15:0] opcode;
  logic [15:0] oper_addr;
  logic [15:0] sw_ram_addr;
  logic [15:0] last_read;
  logic [1:0]  cnf;
  logic        ready_m;
  logic        ready_s;
  logic [15:0] data_m;
  logic [15:0] data_s;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding.

  wire         bus_req    = cyc_i && stb_i && !ack_o;
  wire         wr_fire    = cyc_i && stb_i && ack_o && we_i;
  wire         cmd_write  = wr_fire && adr_i == dsp_ctrl_pkg::OFS_COMMAND && state == S_IDLE;
  wire         is_conf    = opcode[15:2] == dsp_ctrl_pkg::OP_CONF;
  wire         is_mset    = opcode == dsp_ctrl_pkg::OP_MASK_SET;
  wire         is_mclr    = opcode == dsp_ctrl_pkg::OP_MASK_CLR;
  wire         is_fmt     = opcode[15:1] == dsp_ctrl_pkg::OP_FORMAT;
  wire         is_dly     = opcode[15:8] == dsp_ctrl_pkg::OP_MOVE_HI;
  wire         is_ltd     = opcode[15:8] == dsp_ctrl_pkg::OP_LTD_HI;
  wire         is_mac     = opcode[15:8] == dsp_ctrl_pkg::OP_MAC_HI;
  wire         is_move    = is_dly || is_ltd || is_mac;
  wire         is_in      = opcode[15:12] == dsp_ctrl_pkg::OP_IN_HI;
  wire [15:0]  dst_addr   = oper_addr + 16'h0001;
  wire         src_on     = on_chip_data(oper_addr, cnf);
  wire         dst_on     = on_chip_data(dst_addr, cnf);
  wire [9:0]   src_idx    = ram_index(oper_addr);
  wire [9:0]   dst_idx    = ram_index(dst_addr);
  wire [15:0]  src_word   = ram[src_idx];
  wire         move_write = state == S_EXEC && is_move && src_on && dst_on;
  wire         in_store   = state == S_READ && ready_s && is_in && src_on;
  wire         sw_ram_ok  = on_chip_data(sw_ram_addr, 2'h0);
  wire [9:0]   sw_idx     = ram_index(sw_ram_addr);
  wire [31:0]  status_w   = {27'h0, state != S_IDLE, serial_format_bit_o,
                             interrupt_mask_bit_o, cnf};
  wire [31:0]  rd_mux     =
      adr_i == dsp_ctrl_pkg::OFS_COMMAND   ? {16'h0, opcode} :
      adr_i == dsp_ctrl_pkg::OFS_ADDRESS   ? {16'h0, oper_addr} :
      adr_i == dsp_ctrl_pkg::OFS_STATUS    ? status_w :
      adr_i == dsp_ctrl_pkg::OFS_RAM_ADDR  ? {16'h0, sw_ram_addr} :
      adr_i == dsp_ctrl_pkg::OFS_RAM_DATA  ? {16'h0, sw_ram_ok ? ram[sw_idx] : 16'h0} :
      adr_i == dsp_ctrl_pkg::OFS_LAST_READ ? {16'h0, last_read} : 32'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave and software registers.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o       <= 1'b0;
      dat_o       <= 32'h0;
      oper_addr   <= 16'h0;
      sw_ram_addr <= 16'h0;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req && !we_i ? rd_mux : 32'h0;
      if (wr_fire && adr_i == dsp_ctrl_pkg::OFS_ADDRESS && state == S_IDLE) begin
        oper_addr <= merge16(oper_addr, dat_i, sel_i);
      end
      if (wr_fire && adr_i == dsp_ctrl_pkg::OFS_RAM_ADDR) begin
        sw_ram_addr <= merge16(sw_ram_addr, dat_i, sel_i);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_m <= 1'b0;
      ready_s <= 1'b0;
      data_m  <= 16'h0;
      data_s  <= 16'h0;
    end else begin
      ready_m <= ready_i;
      ready_s <= ready_m;
      data_m  <= ext_data_i;
      data_s  <= data_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data RAM.

  always_ff @(posedge clk_i) begin
    if (move_write) begin
      ram[dst_idx] <= src_word;
    end else if (in_store) begin
      ram[src_idx] <= data_s;
    end else if (wr_fire && adr_i == dsp_ctrl_pkg::OFS_RAM_DATA && sw_ram_ok
                 && state == S_IDLE) begin
      ram[sw_idx] <= merge16(ram[sw_idx], dat_i, sel_i);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Execution sequencer and processor bus.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                <= S_IDLE;
      opcode               <= 16'h0;
      cnf                  <= dsp_ctrl_pkg::CNF_RESET;
      interrupt_mask_bit_o <= dsp_ctrl_pkg::MASK_RESET;
      serial_format_bit_o  <= dsp_ctrl_pkg::FORMAT_RESET;
      last_read            <= 16'h0;
      ext_addr_o           <= 16'h0;
      ext_data_o           <= 16'h0;
      ext_data_oe_o        <= 1'b0;
      bus_strobe_n_o       <= 1'b1;
      read_write_o         <= 1'b1;
      io_select_line_n_o   <= 1'b1;
      data_select_n_o      <= 1'b1;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (cmd_write) begin
            opcode <= merge16(opcode, dat_i, sel_i);
            state  <= S_EXEC;
          end
        end
        S_EXEC: begin
          state <= S_IDLE;
          if (is_conf) begin
            cnf <= opcode[1:0];
          end
          if (is_mset) begin
            interrupt_mask_bit_o <= 1'b1;
          end
          if (is_mclr) begin
            interrupt_mask_bit_o <= 1'b0;
          end
          if (is_fmt) begin
            serial_format_bit_o <= opcode[0];
          end
          if (is_move && src_on) begin
            last_read <= src_word;
          end
          if ((is_move && !src_on) || is_in) begin
            state              <= S_READ;
            read_write_o       <= 1'b1;
            bus_strobe_n_o     <= 1'b0;
            ext_addr_o         <= is_in ? {12'h0, opcode[11:8]} : oper_addr;
            io_select_line_n_o <= !is_in;
            data_select_n_o    <= is_in;
          end
        end
        S_READ: begin
          if (ready_s) begin
            last_read          <= data_s;
            bus_strobe_n_o     <= 1'b1;
            io_select_line_n_o <= 1'b1;
            data_select_n_o    <= 1'b1;
            state              <= S_IDLE;
            if (is_in && !src_on) begin
              state           <= S_WRITE;
              ext_addr_o      <= oper_addr;
              ext_data_o      <= data_s;
              ext_data_oe_o   <= 1'b1;
              read_write_o    <= 1'b0;
            end
          end
        end
        S_WRITE: begin
          if (bus_strobe_n_o && !ready_s) begin
            bus_strobe_n_o  <= 1'b0;
            data_select_n_o <= 1'b0;
          end else if (!bus_strobe_n_o && ready_s) begin
            state           <= S_IDLE;
            ext_data_oe_o   <= 1'b0;
            read_write_o    <= 1'b1;
            bus_strobe_n_o  <= 1'b1;
            data_select_n_o <= 1'b1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign ram_config_low_bit_o  = cnf[0];
  assign ram_config_high_bit_o = cnf[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= cmd_write || (state == S_EXEC && (is_in || (is_move && !src_on)))
                || (state == S_READ && (!ready_s || (is_in && !src_on)))
                || (state == S_WRITE && !(ready_s && !bus_strobe_n_o));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_exec_move;
    state == S_EXEC && is_move && src_on && dst_on;
  endsequence

  sequence s_exec_conf2;
    state == S_EXEC && opcode == {dsp_ctrl_pkg::OP_CONF, 2'h2};
  endsequence

  property p_conf_two;
    s_exec_conf2 |=> ram_config_high_bit_o && !ram_config_low_bit_o;
  endproperty
  a_conf_two: assert property (p_conf_two) else $error("Configuration two not applied.");

  property p_move_copy;
    s_exec_move |=> ram[$past(dst_idx)] == $past(src_word);
  endproperty
  a_move_copy: assert property (p_move_copy) else $error("Delay move copy wrong.");

  property p_move_keep;
    s_exec_move |=> ram[$past(src_idx)] == $past(src_word);
  endproperty
  a_move_keep: assert property (p_move_keep) else $error("Delay move source changed.");

  property p_move_region;
    move_write |-> (dst_addr > dsp_ctrl_pkg::B2_BASE
      && dst_addr < dsp_ctrl_pkg::B2_BASE + 16'(dsp_ctrl_pkg::B2_WORDS))
      || (dst_addr > dsp_ctrl_pkg::B0_BASE && dst_addr < dsp_ctrl_pkg::B1_END
      && (cnf == 2'h0 || (dst_addr > dsp_ctrl_pkg::B1_BASE && !cnf[1])));
  endproperty
  a_move_region: assert property (p_move_region) else $error("Move write outside data RAM.");

  property p_move_edge;
    state == S_EXEC && is_move && oper_addr == 16'h02FF && cnf == 2'h0
      |=> ram[10'h100] == $past(src_word);
  endproperty
  a_move_edge: assert property (p_move_edge) else $error("Move broke at block edge.");

  property p_move_ext;
    state == S_EXEC && is_move && !src_on
      |=> !bus_strobe_n_o && read_write_o && !ext_data_oe_o && state == S_READ;
  endproperty
  a_move_ext: assert property (p_move_ext) else $error("External move not read only.");

  property p_mac_move;
    state == S_EXEC && is_mac && src_on && dst_on
      |=> ram[$past(dst_idx)] == $past(src_word) && state == S_IDLE;
  endproperty
  a_mac_move: assert property (p_mac_move) else $error("MAC with move did not move.");

  property p_in_store;
    in_store |=> ram[$past(src_idx)] == $past(data_s);
  endproperty
  a_in_store: assert property (p_in_store) else $error("Port word not stored.");

  property p_in_write;
    state == S_WRITE && !bus_strobe_n_o |-> !read_write_o && ext_data_oe_o
      && !data_select_n_o && io_select_line_n_o && ext_addr_o == oper_addr;
  endproperty
  a_in_write: assert property (p_in_write) else $error("Port word write cycle wrong.");

  property p_in_select;
    !io_select_line_n_o |-> read_write_o && data_select_n_o && !ext_data_oe_o && is_in;
  endproperty
  a_in_select: assert property (p_in_select) else $error("I/O select misused.");

  property p_in_port;
    state == S_EXEC && is_in |=> !io_select_line_n_o && !bus_strobe_n_o
      && ext_addr_o == {12'h0, $past(opcode[11:8])};
  endproperty
  a_in_port: assert property (p_in_port) else $error("Port number not driven.");

  property p_mask_set;
    state == S_EXEC && is_mset |=> interrupt_mask_bit_o [*1];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("Mask bit not set.");

  property p_format;
    state == S_EXEC && is_fmt |=> serial_format_bit_o == $past(opcode[0]);
  endproperty
  a_format: assert property (p_format) else $error("Format bit not copied.");

endmodule : dsp_ctrl_move_io

// >>> tb/ext_bus_model.sv
// Purpose: Peripheral and external memory on the processor bus.
// Assumes: Address, selects and strobe stay put until ready is seen.
// Notes:   Idle data toggles so that a stale word never passes for a read.
`timescale 1ns/10ps
module ext_bus_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        bus_strobe_n_i,
  input  wire logic        read_write_i,
  input  wire logic        io_select_line_n_i,
  input  wire logic        data_select_n_i,
  input  wire logic [15:0] ext_addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_oe_i,
  output logic      [15:0] ext_data_o,
  output logic             ready_o,
  output logic      [15:0] seen_addr_o,
  output logic             seen_io_o,
  output logic      [15:0] seen_wr_o,
  output logic      [7:0]  rd_cnt_o,
  output logic      [7:0]  wr_cnt_o
);
  logic [3:0] wait_cnt = 4'h0;
  initial begin
    ext_data_o = 16'h0000;
    ready_o = 1'b0;
    seen_addr_o = 16'h0000;
    seen_io_o = 1'b0;
    seen_wr_o = 16'h0000;
    rd_cnt_o = 8'h00;
    wr_cnt_o = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Answers each strobe with one space select low after a short or a long wait, for reads and writes alike.
  always @(posedge clk_i) begin
    if (!bus_strobe_n_i) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == 4'h0) begin
        seen_addr_o <= ext_addr_i;
        seen_io_o <= !io_select_line_n_i;
        if (read_write_i) rd_cnt_o <= rd_cnt_o + 8'h01;
        else wr_cnt_o <= wr_cnt_o + 8'h01;
        if (!read_write_i) seen_wr_o <= wr_oe_i ? wr_data_i : 16'h0000;
      end
      // Only a strobe with exactly one space select low is answered.
      if (wait_cnt == (slow_i ? 4'h6 : 4'h0)
          && io_select_line_n_i != data_select_n_i) begin
        ready_o <= 1'b1;
        ext_data_o <= (io_select_line_n_i ? 16'h5A00 : 16'hC300) ^ ext_addr_i;
      end
    end else begin
      wait_cnt <= 4'h0;
      ready_o <= 1'b0;
      ext_data_o <= ~ext_data_o;
    end
  end
endmodule : ext_bus_model

// >>> tb/tb.sv
// Purpose: Self-checking bench for the control, move and port input block.
// Assumes: Register access over classic Wishbone, one command at a time.
// Notes:   Expected words follow the peripheral model's data pattern.
`timescale 1ns/10ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] dat_o, rd;
  logic [15:0] ext_addr_o, ext_data_i, ext_data_o, seen_addr, seen_wr;
  logic        ack_o, ext_data_oe_o, bus_strobe_n_o, read_write_o, io_select_line_n_o;
  logic        data_select_n_o, ready_i, ram_config_low_bit_o, ram_config_high_bit_o;
  logic        interrupt_mask_bit_o, serial_format_bit_o, busy_o, seen_io;
  logic [7:0]  rd_cnt, wr_cnt, r0, w0;
  logic [15:0] ops [4] = '{16'hCE00, 16'hCE0F, 16'hCE01, 16'hCE0E};
  logic [15:0] srcs [3] = '{16'h0200, 16'h02FF, 16'h03FE};
  int          error_cnt = 0;
  int          comparisons = 0;
  always #2 clk_i = ~clk_i;
  dsp_ctrl_move_io dut (.*);
  ext_bus_model partner (.clk_i(clk_i), .slow_i(slow), .bus_strobe_n_i(bus_strobe_n_o),
    .read_write_i(read_write_o), .io_select_line_n_i(io_select_line_n_o),
    .data_select_n_i(data_select_n_o), .ext_addr_i(ext_addr_o), .wr_data_i(ext_data_o),
    .wr_oe_i(ext_data_oe_o), .ext_data_o(ext_data_i), .ready_o(ready_i),
    .seen_addr_o(seen_addr), .seen_io_o(seen_io), .seen_wr_o(seen_wr), .rd_cnt_o(rd_cnt),
    .wr_cnt_o(wr_cnt));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    if (n == 50) chk(32'h0, 32'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task automatic stat_chk(input logic f, input logic m, input logic [1:0] k);
    wb(1'b0, dsp_ctrl_pkg::OFS_STATUS, 32'h0);
    chk(rd, {27'h0, 1'b0, f, m, k});
    chk({28'h0, ram_config_high_bit_o, ram_config_low_bit_o, interrupt_mask_bit_o,
      serial_format_bit_o}, {28'h0, k, m, f});
  endtask : stat_chk
  task automatic cmd(input logic [15:0] a, input logic [15:0] op);
    int n;
    n = 0;
    wb(1'b1, dsp_ctrl_pkg::OFS_ADDRESS, {16'h0, a});
    wb(1'b1, dsp_ctrl_pkg::OFS_COMMAND, {16'h0, op});
    do begin
      wb(1'b0, dsp_ctrl_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[dsp_ctrl_pkg::STAT_BUSY] !== 1'b0 && n < 100);
    if (n == 100) chk(32'h0, 32'h1);
    chk({31'h0, busy_o}, 32'h0);
  endtask : cmd
  task automatic ram_wr(input logic [15:0] a, input logic [15:0] d);
    wb(1'b1, dsp_ctrl_pkg::OFS_RAM_ADDR, {16'h0, a});
    wb(1'b1, dsp_ctrl_pkg::OFS_RAM_DATA, {16'h0, d});
  endtask : ram_wr
  task automatic ram_chk(input logic [15:0] a, input logic [15:0] e);
    wb(1'b1, dsp_ctrl_pkg::OFS_RAM_ADDR, {16'h0, a});
    wb(1'b0, dsp_ctrl_pkg::OFS_RAM_DATA, 32'h0);
    chk(rd, {16'h0, e});
  endtask : ram_chk
  task automatic results;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    stat_chk(1'b0, 1'b1, 2'h0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      cmd(16'h0, 16'hCE3C | 16'(k));
      stat_chk(1'b0, 1'b1, 2'(k));
    end
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      cmd(16'h0, ops[i]);
      stat_chk(1'(i == 1 || i == 2), 1'(i > 1), 2'h3);
    end
    $display("test mask and format done");
    cmd(16'h0, 16'hCE3E);
    ram_wr(16'h0060, 16'h1234);
    ram_wr(16'h0061, 16'h0000);
    cmd(16'h0060, 16'h5660);
    ram_chk(16'h0061, 16'h1234);
    ram_chk(16'h0060, 16'h1234);
    for (int i = 0; i < 2; i++) begin
      ram_wr(16'h0062, 16'hBEE0 + 16'(i));
      cmd(16'h0062, {i ? dsp_ctrl_pkg::OP_MAC_HI : dsp_ctrl_pkg::OP_LTD_HI, 8'h62});
      ram_chk(16'h0063, 16'hBEE0 + 16'(i));
    end
    ram_wr(16'h0200, 16'h5555);
    ram_wr(16'h0201, 16'h0000);
    cmd(16'h0200, 16'h5600);
    ram_chk(16'h0201, 16'h0000);
    $display("test block two move done");
    cmd(16'h0, 16'hCE3C);
    for (int i = 0; i < 3; i++) begin
      ram_wr(srcs[i], 16'h0A00 + 16'(i));
      ram_wr(srcs[i] + 16'h1, 16'h0000);
      cmd(srcs[i], {8'h56, 1'b0, srcs[i][6:0]});
      ram_chk(srcs[i] + 16'h1, 16'h0A00 + 16'(i));
      ram_chk(srcs[i], 16'h0A00 + 16'(i));
    end
    $display("test boundary move done");
    slow <= 1'b1;
    r0 = rd_cnt;
    w0 = wr_cnt;
    cmd(16'h8000, 16'h5600);
    chk({24'h0, rd_cnt}, {24'h0, r0 + 8'h01});
    chk({24'h0, wr_cnt}, {24'h0, w0});
    chk({15'h0, seen_io, seen_addr}, 32'h8000);
    wb(1'b0, dsp_ctrl_pkg::OFS_LAST_READ, 32'h0);
    chk(rd, 32'h0000DA00);
    $display("test external move done");
    for (int p = 5; p < 16; p += 10) begin
      slow <= 1'(p > 5);
      cmd(16'h0061, {4'h8, 4'(p), 8'h61});
      ram_chk(16'h0061, 16'hC300 + 16'(p));
      chk({15'h0, seen_io, seen_addr}, 32'h10000 + 32'(p));
    end
    r0 = rd_cnt;
    w0 = wr_cnt;
    cmd(16'h8100, 16'h8300);
    chk({16'h0, rd_cnt, wr_cnt}, {16'h0, r0 + 8'h01, w0 + 8'h01});
    chk({seen_wr, seen_addr}, {16'hC303, 16'h8100});
    $display("test port input done");
    results();
  end
endmodule : tb
